//--- design/psc_pkg.sv
// package: offsets, reset values and timing for the strap loader and power-good block
package psc_pkg;
  localparam int PSC_CLK_MHZ = 100;
  // timing in its own unit, cycles derived
  localparam int PSC_BIAS_SETTLE_US = 20;
  localparam int PSC_BIAS_CYCLES = PSC_BIAS_SETTLE_US * PSC_CLK_MHZ;
  localparam int PSC_RAMP_STEP_US = 1;
  localparam int PSC_RAMP_CYCLES = PSC_RAMP_STEP_US * PSC_CLK_MHZ;
  localparam int PSC_DIGITAL_PULSE_MODULATOR_STEP_PS = 163;
  // register byte offsets
  localparam logic [7:0] PSC_PIN_SETUP = 8'h00;
  localparam logic [7:0] PSC_ON_OFF_CFG = 8'h04;
  localparam logic [7:0] PSC_OPERATION = 8'h08;
  localparam logic [7:0] PSC_VOUT_CMD = 8'h0c;
  localparam logic [7:0] PSC_VOUT_NOM = 8'h10;
  localparam logic [7:0] PSC_STATUS = 8'h14;
  localparam logic [7:0] PSC_SETPOINT = 8'h18;
  localparam logic [7:0] PSC_COMP_SEL = 8'h1c;
  localparam logic [7:0] PSC_IRQ_STAT = 8'h20;
  localparam logic [7:0] PSC_IRQ_MASK = 8'h24;
  // pin setup fields
  localparam int PSC_PS_VSET_DIS = 0;
  localparam int PSC_PS_SYNC_LO = 1;
  localparam int PSC_PS_TRISTATE = 3;
  // sync modes
  localparam logic [1:0] PSC_SYNC_OFF = 2'h0;
  localparam logic [1:0] PSC_SYNC_IN = 2'h1;
  localparam logic [1:0] PSC_SYNC_OUT = 2'h2;
  // enable source
  localparam logic [1:0] PSC_EN_PIN_HI = 2'h0;
  localparam logic [1:0] PSC_EN_PIN_LO = 2'h1;
  localparam logic [1:0] PSC_EN_CMD = 2'h2;
  localparam logic [1:0] PSC_EN_BOTH = 2'h3;
  // voltages in mV
  localparam logic [10:0] PSC_VREF_MAX_MV = 11'h5a0;
  localparam logic [10:0] PSC_VOUT_NOM_RST = 11'h320;
  localparam logic [4:0] PSC_STRAP_CODES = 5'h1e;
  localparam logic [4:0] PSC_VSET_RSVD = 5'h02;
  localparam int PSC_COMP_ENTRIES = 6;
  localparam logic [4:0] PSC_COMP_RST = 5'h00;
  // interrupt bits
  localparam int PSC_IRQ_STRAP = 0;
  localparam int PSC_IRQ_PG_FALL = 1;
  localparam int PSC_IRQ_PG_RISE = 2;
  localparam int PSC_IRQ_RAMP = 3;
  localparam int PSC_IRQ_RSVD = 4;
  localparam int PSC_IRQ_W = 5;
  typedef enum logic [5:0] {
    PSC_ST_IDLE  = 6'b000001,
    PSC_ST_BIAS  = 6'b000010,
    PSC_ST_CONV  = 6'b000100,
    PSC_ST_NEXT  = 6'b001000,
    PSC_ST_LOAD  = 6'b010000,
    PSC_ST_RUN   = 6'b100000
  } psc_state_t;
endpackage

//--- design/psc_vset_decode.sv
// setpoint strap code to millivolt lookup
module psc_vset_decode
  import psc_pkg::*;
(
  input wire logic [4:0] code,
  output logic [10:0] vout_mv,
  output logic reserved
);
  always_comb begin
    reserved = (code < PSC_VSET_RSVD) || (code >= PSC_STRAP_CODES);
    case (code)
      5'h02: vout_mv = 11'd1300;
      5'h03: vout_mv = 11'd1250;
      5'h04: vout_mv = 11'd1200;
      5'h05: vout_mv = 11'd1175;
      5'h06: vout_mv = 11'd1150;
      5'h07: vout_mv = 11'd1120;
      5'h08: vout_mv = 11'd1100;
      5'h09: vout_mv = 11'd1050;
      5'h0a: vout_mv = 11'd1030;
      5'h0b: vout_mv = 11'd1000;
      5'h0c: vout_mv = 11'd975;
      5'h0d: vout_mv = 11'd950;
      5'h0e: vout_mv = 11'd920;
      5'h0f: vout_mv = 11'd900;
      5'h10: vout_mv = 11'd890;
      5'h11: vout_mv = 11'd875;
      5'h12: vout_mv = 11'd850;
      5'h13: vout_mv = 11'd825;
      5'h14: vout_mv = 11'd800;
      5'h15: vout_mv = 11'd775;
      5'h16: vout_mv = 11'd750;
      5'h17: vout_mv = 11'd720;
      5'h18: vout_mv = 11'd700;
      5'h19: vout_mv = 11'd650;
      5'h1a: vout_mv = 11'd600;
      5'h1b: vout_mv = 11'd550;
      5'h1c: vout_mv = 11'd520;
      5'h1d: vout_mv = 11'd500;
      default: vout_mv = 11'd0;
    endcase
  end
endmodule

//--- design/psc_pg_compare.sv
// in-regulation compare: sense at or above 90 percent of setpoint
module psc_pg_compare
  import psc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [10:0] sense_mv,
  input wire logic [10:0] setpoint_mv,
  output logic in_reg
);
  logic [14:0] lhs;
  logic [14:0] rhs;
  assign lhs = {1'b0, sense_mv, 3'h0} + {3'h0, sense_mv, 1'b0};
  assign rhs = {1'b0, setpoint_mv, 3'h0} + {4'h0, setpoint_mv};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reg <= 1'b0;
    end else begin
      in_reg <= (setpoint_mv != 11'h000) && (lhs >= rhs);
    end
  end
endmodule

//--- design/psc_strap_ctrl.sv
// strap loader, enable policy, setpoint ramp, power-good and apb registers
module psc_strap_ctrl
  import psc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic strap_adc_done,
  input wire logic [4:0] strap_adc_code,
  output logic strap_bias_en,
  output logic strap_sel_tune,
  output logic strap_adc_start,
  input wire logic run_pin,
  input wire logic major_fault,
  input wire logic [10:0] vout_sense_mv,
  output logic [10:0] vref_mv,
  output logic [2:0] comp_family,
  output logic [2:0] comp_entry,
  output logic run_enable,
  output logic modulator_tristate,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic sync_enable,
  output logic output_good_flag_out,
  output logic output_good_flag_oe,
  output logic irq
);
  psc_state_t state;
  logic [15:0] wait_cnt;
  logic [4:0] vset_code;
  logic [4:0] comp_code;
  logic strap_done;
  logic [3:0] pin_setup;
  logic [1:0] on_off_cfg;
  logic op_on;
  logic [10:0] vout_target;
  logic [10:0] vout_nom;
  logic ramping;
  logic [7:0] ramp_cnt;
  logic pg;
  logic [PSC_IRQ_W-1:0] irq_stat;
  logic [PSC_IRQ_W-1:0] irq_mask;
  logic [PSC_IRQ_W-1:0] irq_event;
  logic [10:0] dec_mv;
  logic dec_rsvd;
  logic in_reg;
  logic apb_done;
  logic apb_wr;
  logic apb_rd;
  logic en_req;
  logic next_pg;
  logic [10:0] wr_mv;
  logic [31:0] rd_word;
  logic rd_err;

  // a transfer completes on the edge that samples pready high
  assign apb_done = psel && penable && pready;
  assign apb_wr = apb_done && pwrite;
  assign apb_rd = apb_done && !pwrite;
  assign wr_mv = (pwdata[10:0] > PSC_VREF_MAX_MV) ? PSC_VREF_MAX_MV : pwdata[10:0];

  // strap code to millivolts; codes outside the table are flagged reserved
  psc_vset_decode u_dec (
    .code(vset_code),
    .vout_mv(dec_mv),
    .reserved(dec_rsvd)
  );

  // registered compare of sense against 90 percent of the reference
  psc_pg_compare u_pg (
    .pclk(pclk),
    .presetn(presetn),
    .sense_mv(vout_sense_mv),
    .setpoint_mv(vref_mv),
    .in_reg(in_reg)
  );

  // power-up strap sequence: setpoint strap first, then compensation strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PSC_ST_IDLE;
      wait_cnt <= 16'h0000;
      strap_bias_en <= 1'b0;
      strap_sel_tune <= 1'b0;
      strap_adc_start <= 1'b0;
      vset_code <= 5'h00;
      comp_code <= PSC_COMP_RST;
      strap_done <= 1'b0;
    end else begin
      strap_adc_start <= 1'b0;
      case (state)
        PSC_ST_IDLE: begin
          strap_bias_en <= 1'b1;
          wait_cnt <= 16'h0000;
          state <= PSC_ST_BIAS;
        end
        PSC_ST_BIAS: begin
          if (wait_cnt == 16'(PSC_BIAS_CYCLES - 1)) begin
            strap_adc_start <= 1'b1;
            state <= PSC_ST_CONV;
          end else begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        PSC_ST_CONV: begin
          if (strap_adc_done) begin
            if (strap_sel_tune) begin
              comp_code <= (strap_adc_code < PSC_STRAP_CODES) ? strap_adc_code
                : PSC_COMP_RST;
              state <= PSC_ST_LOAD;
            end else begin
              vset_code <= strap_adc_code;
              state <= PSC_ST_NEXT;
            end
          end
        end
        PSC_ST_NEXT: begin
          // second pass digitizes the compensation strap
          strap_sel_tune <= 1'b1;
          wait_cnt <= 16'h0000;
          state <= PSC_ST_BIAS;
        end
        PSC_ST_LOAD: begin
          // release the bias and latch the strap results
          strap_bias_en <= 1'b0;
          strap_sel_tune <= 1'b0;
          strap_done <= 1'b1;
          state <= PSC_ST_RUN;
        end
        PSC_ST_RUN: begin
          if (apb_wr && paddr == PSC_COMP_SEL && pwdata[4:0] < PSC_STRAP_CODES) begin
            comp_code <= pwdata[4:0];
          end
        end
        default: state <= PSC_ST_IDLE;
      endcase
    end
  end

  // five families of six entries; family 0 is the mixed capacitor default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_family <= 3'h0;
      comp_entry <= 3'h0;
    end else begin
      comp_family <= 3'(comp_code / 5'(PSC_COMP_ENTRIES));
      comp_entry <= 3'(comp_code % 5'(PSC_COMP_ENTRIES));
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_setup <= 4'h0;
      on_off_cfg <= PSC_EN_PIN_HI;
      op_on <= 1'b0;
      vout_nom <= PSC_VOUT_NOM_RST;
      irq_mask <= '0;
    end else if (apb_wr) begin
      case (paddr)
        PSC_PIN_SETUP: pin_setup <= pwdata[3:0];
        PSC_ON_OFF_CFG: on_off_cfg <= pwdata[1:0];
        PSC_OPERATION: op_on <= pwdata[7];
        // nominal start voltage shares the reference ceiling
        PSC_VOUT_NOM: vout_nom <= wr_mv;
        PSC_IRQ_MASK: irq_mask <= pwdata[PSC_IRQ_W-1:0];
        default: op_on <= op_on;
      endcase
    end
  end

  // setpoint target: strap or nominal at load, command at any time after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vout_target <= 11'h000;
    end else if (state == PSC_ST_LOAD) begin
      if (pin_setup[PSC_PS_VSET_DIS] || dec_rsvd) begin
        vout_target <= vout_nom;
      end else begin
        vout_target <= dec_mv;
      end
    end else if (apb_wr && paddr == PSC_VOUT_CMD && strap_done) begin
      vout_target <= wr_mv;
    end
  end

  // reference moves one mV per step toward target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vref_mv <= 11'h000;
      ramping <= 1'b0;
      ramp_cnt <= 8'h00;
    end else if (state == PSC_ST_RUN && vref_mv == 11'h000) begin
      // first entry to run jumps straight to the target, no ramp
      vref_mv <= vout_target;
    end else if (vref_mv != vout_target && state == PSC_ST_RUN) begin
      ramping <= 1'b1;
      if (ramp_cnt == 8'(PSC_RAMP_CYCLES - 1)) begin
        ramp_cnt <= 8'h00;
        vref_mv <= (vref_mv < vout_target) ? vref_mv + 11'h001 : vref_mv - 11'h001;
      end else begin
        ramp_cnt <= ramp_cnt + 8'h01;
      end
    end else begin
      ramping <= 1'b0;
      ramp_cnt <= 8'h00;
    end
  end

  // enable policy
  always_comb begin
    case (on_off_cfg)
      PSC_EN_PIN_HI: en_req = run_pin;
      PSC_EN_PIN_LO: en_req = !run_pin;
      PSC_EN_CMD: en_req = op_on;
      PSC_EN_BOTH: en_req = run_pin && op_on;
      default: en_req = 1'b0;
    endcase
  end

  // good needs enable, no fault, regulation and a settled reference
  assign next_pg = run_enable && !major_fault && in_reg && !ramping;

  // run enable, power-good pin and modulator outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_enable <= 1'b0;
      pg <= 1'b0;
      output_good_flag_out <= 1'b0;
      output_good_flag_oe <= 1'b0;
      modulator_tristate <= 1'b1;
    end else begin
      run_enable <= strap_done && en_req && !major_fault;
      pg <= next_pg;
      output_good_flag_out <= 1'b0;
      output_good_flag_oe <= !next_pg && !ramping;
      modulator_tristate <= !run_enable || pin_setup[PSC_PS_TRISTATE];
    end
  end

  // sync pin direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_oe <= 1'b0;
      sync_out <= 1'b0;
      sync_enable <= 1'b0;
    end else begin
      sync_oe <= pin_setup[PSC_PS_SYNC_LO +: 2] == PSC_SYNC_OUT;
      sync_enable <= pin_setup[PSC_PS_SYNC_LO +: 2] != PSC_SYNC_OFF;
      // input mode echoes the pin, output mode sends the run state
      sync_out <= (pin_setup[PSC_PS_SYNC_LO +: 2] == PSC_SYNC_IN) ? sync_in : run_enable;
    end
  end

  // sticky events, read of status clears, new event wins over clear
  always_comb begin
    irq_event = '0;
    irq_event[PSC_IRQ_STRAP] = state == PSC_ST_LOAD;
    irq_event[PSC_IRQ_PG_FALL] = pg && !next_pg;
    irq_event[PSC_IRQ_PG_RISE] = !pg && next_pg;
    irq_event[PSC_IRQ_RAMP] = ramping && vref_mv == vout_target;
    irq_event[PSC_IRQ_RSVD] = state == PSC_ST_LOAD && dec_rsvd
      && !pin_setup[PSC_PS_VSET_DIS];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      if (apb_rd && paddr == PSC_IRQ_STAT) begin
        irq_stat <= irq_event;
      end else begin
        irq_stat <= irq_stat | irq_event;
      end
      // level output while any unmasked bit is set or being set
      irq <= |((irq_stat | irq_event) & irq_mask);
    end
  end

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      PSC_PIN_SETUP: rd_word[3:0] = pin_setup;
      PSC_ON_OFF_CFG: rd_word[1:0] = on_off_cfg;
      PSC_OPERATION: rd_word[7] = op_on;
      PSC_VOUT_CMD: rd_word[10:0] = vout_target;
      PSC_VOUT_NOM: rd_word[10:0] = vout_nom;
      PSC_STATUS: rd_word[15:0] = {vset_code, comp_code, ramping, pg, run_enable,
        major_fault, in_reg, strap_done};
      PSC_SETPOINT: rd_word[10:0] = vref_mv;
      PSC_COMP_SEL: rd_word[4:0] = comp_code;
      PSC_IRQ_STAT: rd_word[PSC_IRQ_W-1:0] = irq_stat;
      PSC_IRQ_MASK: rd_word[PSC_IRQ_W-1:0] = irq_mask;
      default: rd_err = 1'b1;
    endcase
  end

  // apb: data captured in setup, ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // pready pulses for one cycle in the first access cycle
      pready <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end
endmodule

//--- dv/psc_chk_assertions.sv
// checker: port relations of the strap loader and power-good logic
module psc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic strap_bias_en,
  input wire logic strap_adc_start,
  input wire logic run_enable,
  input wire logic major_fault,
  input wire logic [10:0] vout_sense_mv,
  input wire logic [10:0] vref_mv,
  input wire logic sync_oe,
  input wire logic sync_enable,
  input wire logic output_good_flag_out,
  input wire logic output_good_flag_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] calm;
  logic lo;
  logic hi;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign lo = {4'h0, vout_sense_mv} * 15'ha < {4'h0, vref_mv} * 15'h9;
  assign hi = calm > 8'hc8 && vref_mv != 11'h0;
  // cycles since the setpoint last moved, so ramps are excluded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calm <= 8'h0;
    end else if ($changed(vref_mv)) begin
      calm <= 8'h0;
    end else if (calm != 8'hff) begin
      calm <= calm + 8'h1;
    end
  end
  chk_pg_pulls_only: assert property (!output_good_flag_out)
    else $error("pg pin driven high");
  chk_vref_ceiling: assert property (vref_mv <= 11'h5a0)
    else $error("setpoint above ceiling");
  chk_ramp_release: assert property ($changed(vref_mv) && $past(vref_mv) != 11'h0 |-> !output_good_flag_oe)
    else $error("pg pulled during ramp");
  chk_below_low: assert property ((hi && lo) [*3] |-> output_good_flag_oe)
    else $error("pg released below threshold");
  chk_fault_low: assert property ((hi && major_fault) [*3] |-> output_good_flag_oe)
    else $error("pg released on fault");
  chk_good_free: assert property ((hi && run_enable && !major_fault && !lo) [*3] |-> !output_good_flag_oe)
    else $error("pg pulled in regulation");
  chk_start_pulse: assert property (strap_adc_start |=> !strap_adc_start)
    else $error("start longer than one cycle");
  chk_bias_before: assert property (strap_adc_start |-> strap_bias_en && $past(strap_bias_en, 8))
    else $error("conversion without bias");
  chk_sync_dir: assert property (sync_oe |-> sync_enable)
    else $error("sync driven while off");
  cover property (strap_adc_start);
  cover property ((hi && lo) [*3]);
  cover property ($changed(vref_mv) && $past(vref_mv) != 11'h0);
endmodule

bind psc_strap_ctrl psc_chk i_chk (
  .pclk(pclk), .presetn(presetn), .strap_bias_en(strap_bias_en),
  .strap_adc_start(strap_adc_start), .run_enable(run_enable), .major_fault(major_fault),
  .vout_sense_mv(vout_sense_mv), .vref_mv(vref_mv), .sync_oe(sync_oe),
  .sync_enable(sync_enable), .output_good_flag_out(output_good_flag_out),
  .output_good_flag_oe(output_good_flag_oe)
);

//--- dv/psc_strap_model.sv
// partner: strap resistors and their digitizer
module psc_strap_model (
  input wire logic pclk,
  input wire logic strap_bias_en,
  input wire logic strap_sel_tune,
  input wire logic strap_adc_start,
  input wire logic [4:0] vset_code,
  input wire logic [4:0] tune_code,
  input wire logic [7:0] lag,
  output logic strap_adc_done,
  output logic [4:0] strap_adc_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] left = 9'h0;
  initial begin
    strap_adc_done = 1'b0;
    strap_adc_code = 5'ha;
  end
  // code is only valid with done; it wanders otherwise
  always @(posedge pclk) begin
    strap_adc_done <= 1'b0;
    strap_adc_code <= ~strap_adc_code;
    if (strap_adc_start && strap_bias_en) begin
      left <= {1'b0, lag};
    end else if (left == 9'h1) begin
      left <= 9'h0;
      strap_adc_done <= 1'b1;
      strap_adc_code <= strap_sel_tune ? tune_code : vset_code;
    end else if (left != 9'h0) begin
      left <= left - 9'h1;
    end
  end
endmodule

//--- dv/testbench.sv
// testbench: apb sequences for the strap loader and power-good block
module testbench
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic run_pin = 1'b1;
  logic sync_in = 1'b0;
  logic fault = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [7:0] lag = 8'h1;
  logic [31:0] pwdata = 32'h0;
  logic [10:0] sense = 11'h514;
  logic [31:0] prdata, rd;
  logic [10:0] vref;
  logic [4:0] code;
  logic [2:0] fam, ent;
  logic pready, pslverr, er, done, bias, tune, start;
  logic run_en, tri_st, sync_oe, sync_en, sync_out, pg_oe, irq;
  int n_fail = 0;
  int tests_run = 0;
  always #5 pclk = ~pclk;
  psc_strap_ctrl i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_adc_done(done), .strap_adc_code(code), .strap_bias_en(bias),
    .strap_sel_tune(tune), .strap_adc_start(start), .run_pin(run_pin),
    .major_fault(fault), .vout_sense_mv(sense), .vref_mv(vref), .comp_family(fam),
    .comp_entry(ent), .run_enable(run_en), .modulator_tristate(tri_st), .sync_in(sync_in),
    .sync_out(sync_out), .sync_oe(sync_oe), .sync_enable(sync_en), .output_good_flag_out(),
    .output_good_flag_oe(pg_oe), .irq(irq)
  );
  psc_strap_model i_strap (.pclk(pclk), .strap_bias_en(bias), .strap_sel_tune(tune),
    .strap_adc_start(start), .vset_code(5'h2), .tune_code(5'h8), .lag(lag),
    .strap_adc_done(done), .strap_adc_code(code));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_fail++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic wait_strap();
    int k;
    k = 0;
    do begin
      repeat (50) @(posedge pclk);
      apb(1'b0, PSC_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'b1 && k < 200);
    if (k >= 200) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic pg(input logic [10:0] s, input logic f, input logic e);
    @(posedge pclk);
    sense <= s;
    fault <= f;
    settle(4);
    chk("pg", {31'h0, e}, {31'h0, pg_oe});
  endtask
  function automatic logic exp_run(input int m, input int v);
    case (m)
      0: return v[0];
      1: return !v[0];
      2: return v[1];
      default: return v[0] && v[1];
    endcase
  endfunction
  initial begin
    settle(7);
    chk("tristate", 32'h1, {31'h0, tri_st});
    chk("pg reset", 32'h0, {31'h0, pg_oe});
    chk("sync reset", 32'h0, {31'h0, sync_en});
    @(posedge pclk);
    presetn <= 1'b1;
    wait_strap();
    settle(4);
    chk("vref", 32'h514, {21'h0, vref});
    chk("family", 32'h1, {29'h0, fam});
    chk("entry", 32'h2, {29'h0, ent});
    rdc("setpoint", PSC_SETPOINT, 32'h514);
    settle(1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, PSC_IRQ_MASK, 32'h1);
    settle(1);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, PSC_IRQ_STAT, 32'h0);
    chk("irq stat", 32'h1, rd & 32'h1);
    settle(1);
    chk("irq clear", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h8000_0000, {er, rd[30:0]});
    apb(1'b1, PSC_COMP_SEL, 32'h1d);
    settle(2);
    chk("user comp", 32'h25, {26'h0, fam, ent});
    for (int m = 0; m < 4; m++) begin
      for (int v = 0; v < 4; v++) begin
        apb(1'b1, PSC_ON_OFF_CFG, 32'(m));
        apb(1'b1, PSC_OPERATION, {24'h0, v[1], 7'h0});
        @(posedge pclk);
        run_pin <= v[0];
        settle(3);
        chk("run", {31'h0, exp_run(m, v)}, {31'h0, run_en});
      end
    end
    apb(1'b1, PSC_ON_OFF_CFG, 32'h0);
    apb(1'b1, PSC_PIN_SETUP, 32'h2);
    settle(2);
    chk("sync in", 32'h2, {30'h0, sync_en, sync_oe});
    chk("sync echo lo", 32'h0, {31'h0, sync_out});
    @(posedge pclk);
    sync_in <= 1'b1;
    settle(2);
    chk("sync echo hi", 32'h1, {31'h0, sync_out});
    apb(1'b1, PSC_PIN_SETUP, 32'h4);
    settle(2);
    chk("sync out", 32'h3, {30'h0, sync_en, sync_oe});
    apb(1'b1, PSC_PIN_SETUP, 32'h8);
    settle(2);
    chk("forced tristate", 32'h1, {31'h0, tri_st});
    apb(1'b1, PSC_PIN_SETUP, 32'h0);
    apb(1'b1, PSC_VOUT_CMD, 32'h50a);
    settle(110);
    pg(11'h0, 1'b0, 1'b0);
    settle(300);
    chk("pg ramp", 32'h0, {31'h0, pg_oe});
    settle(900);
    chk("vref cmd", 32'h50a, {21'h0, vref});
    pg(11'h0, 1'b0, 1'b1);
    pg(11'h489, 1'b0, 1'b0);
    pg(11'h488, 1'b0, 1'b1);
    pg(11'h489, 1'b1, 1'b1);
    pg(11'h489, 1'b0, 1'b0);
    apb(1'b1, PSC_VOUT_CMD, 32'h5dc);
    rdc("clamp", PSC_VOUT_CMD, 32'h5a0);
    @(posedge pclk);
    lag <= 8'hc8;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, PSC_PIN_SETUP, 32'h1);
    apb(1'b1, PSC_VOUT_NOM, 32'h3e8);
    wait_strap();
    settle(4);
    chk("nominal start", 32'h3e8, {21'h0, vref});
    chk("family kept", 32'h1, {29'h0, fam});
    wrap_up();
  end
endmodule
